// ===== rtl/vwr_pkg.sv
// Constants and types shared by the word registration command block
package vwr_pkg;
  // Command nibble codes
  localparam logic [3:0] IDLE_CODE = 4'h0;
  localparam logic [3:0] FORBIDDEN_CODE = 4'hB;
  localparam logic [3:0] BANK_SELECT_CMD = 4'hC;
  localparam logic [3:0] STORE_WORD_CMD = 4'hD;
  localparam logic [3:0] ERASE_WORD_CMD = 4'hE;
  localparam logic [3:0] ERASE_ALL_CMD = 4'hF;
  localparam logic [3:0] MAX_NUMERAL = 4'hA;
  localparam logic [3:0] MAX_BANK_NUMERAL = 4'h4;
  // Word result codes beyond slot numbers
  localparam logic [3:0] WORD_NO_MATCH = 4'hD;
  localparam logic [3:0] WORD_TOO_SHORT = 4'hE;
  localparam logic [3:0] WORD_TOO_LONG = 4'hF;
  localparam logic [3:0] WORD_RESET = 4'h0;
  localparam logic [1:0] BANK_RESET = 2'h0;
  // Capture status from the speech engine
  localparam logic [1:0] CAP_OK = 2'h0;
  localparam logic [1:0] CAP_SHORT = 2'h1;
  localparam logic [1:0] CAP_LONG = 2'h2;
  // Slot table shape
  localparam int SLOT_COUNT = 40;
  localparam logic [5:0] WORDS_PER_BANK = 6'h0A;
  // Register map, byte addresses
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] OCC_LO_OFFSET = 12'h008;
  localparam logic [11:0] OCC_HI_OFFSET = 12'h00C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_LISTEN_BIT = 0;
  // Post recognition hold-off
  localparam int HOLDOFF_MS = 11;
  localparam int CLOCK_HZ = 10_000_000;
  localparam int HOLDOFF_CYCLES = HOLDOFF_MS * (CLOCK_HZ / 1000);
  typedef enum logic {VWR_READY, VWR_LISTEN} vwr_state_t;
endpackage

// ===== rtl/vwr_command_core.sv
// Command decode, slot table and result lines of the word recognizer
// Notes on behaviour
// - Code 1100 makes last numeral active bank
// - Training entry selects bank one
// - Code 1101 picks slot, then awaits speech
// - Any code while awaiting speech aborts
// - Registration end shows bank, slot or error
// - Code 1110 erases numbered slot in bank
// - Code 1111 erases every slot
// - Empty slots never match in recognition
// - Zero idle, one-ten numerals, top four commands
// - Nonzero after idle is a new code
// - Bank one-four shown as zero-three
// - Slot value shown; 1110 short, 1111 long
// - Recognition adds 1101 for no match
// - Storing into used slot overwrites it
// - Bank numeral above four wraps, flags fault
// - Latest numeral is the command argument
// - Recognition starts on speech without command
// - Speech ignored eleven ms after recognition
// - Standby halts, keeps stored entries
// - Done flag low during speech, high after
// - Train select high trains, low recognizes
// - Host select high uses command lines
// - Results hold, are low after reset
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module vwr_command_core #(
  parameter int unsigned HOLDOFF_CYCLES = vwr_pkg::HOLDOFF_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [3:0] command_nibble_lines,
  input wire logic [3:0] keypad_code,
  input wire logic train_mode_select,
  input wire logic host_control_select,
  input wire logic standby_request,
  input wire logic speech_active,
  input wire logic capture_done,
  input wire logic [1:0] capture_status,
  input wire logic match_done,
  input wire logic match_found,
  input wire logic [1:0] match_status,
  input wire logic [1:0] match_bank,
  input wire logic [3:0] match_word,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic result_bank_bit0,
  output logic result_bank_bit1,
  output logic [3:0] result_word_lines,
  output logic result_done_flag,
  output logic busy_flag,
  output logic listen_enable,
  output logic [39:0] slot_occupied
);
  logic [3:0] cmd_meta, cmd_sync, key_meta, key_sync, prev_code;
  logic train_meta, train_sync, train_prev;
  logic host_meta, host_sync, standby_request_meta, standby_request_sync, standby_request_prev;
  logic [3:0] numeral;
  logic [1:0] bank;
  logic [3:0] slot;
  logic bank_fault;
  logic [31:0] ctrl;
  logic [16:0] holdoff;
  vwr_pkg::vwr_state_t state;
  logic [3:0] code;
  logic run, new_code, is_numeral, cmd_ok;
  logic store_hit, erase_word_hit, erase_all_hit, match_hit;
  logic [5:0] store_idx, erase_idx, match_idx;
  logic match_valid;

  // Slot number inside the flat 40 entry table
  function automatic logic [5:0] slot_idx(input logic [1:0] b, input logic [3:0] w);
    logic [5:0] sum;
    sum = 6'({4'h0, b} * vwr_pkg::WORDS_PER_BANK) + {2'h0, w};
    slot_idx = sum - 6'h01;
  endfunction

  // Pin synchronisers; only the second stage is ever read by logic
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cmd_meta <= 4'h0;
      cmd_sync <= 4'h0;
      key_meta <= 4'h0;
      key_sync <= 4'h0;
      train_meta <= 1'b0;
      train_sync <= 1'b0;
      host_meta <= 1'b0;
      host_sync <= 1'b0;
      standby_request_meta <= 1'b0;
      standby_request_sync <= 1'b0;
    end else if (ce) begin
      cmd_meta <= command_nibble_lines;
      cmd_sync <= cmd_meta;
      key_meta <= keypad_code;
      key_sync <= key_meta;
      train_meta <= train_mode_select;
      train_sync <= train_meta;
      host_meta <= host_control_select;
      host_sync <= host_meta;
      standby_request_meta <= standby_request;
      standby_request_sync <= standby_request_meta;
    end
  end

  // Code source and decode
  always_comb begin
    code = host_sync ? cmd_sync : key_sync;
    run = ce & ~standby_request_sync;
    new_code = run && code != vwr_pkg::IDLE_CODE && prev_code == vwr_pkg::IDLE_CODE;
    is_numeral = code != vwr_pkg::IDLE_CODE && code <= vwr_pkg::MAX_NUMERAL;
    cmd_ok = new_code && train_sync && state == vwr_pkg::VWR_READY;
    store_hit = run && state == vwr_pkg::VWR_LISTEN && capture_done && ctrl[0]
      && capture_status == vwr_pkg::CAP_OK;
    store_idx = slot_idx(bank, slot);
    erase_word_hit = cmd_ok && code == vwr_pkg::ERASE_WORD_CMD
      && numeral != 4'h0 && numeral <= vwr_pkg::MAX_NUMERAL;
    erase_idx = slot_idx(bank, numeral);
    erase_all_hit = cmd_ok && code == vwr_pkg::ERASE_ALL_CMD;
    match_hit = run && !train_sync && listen_enable && match_done;
    match_idx = slot_idx(match_bank, match_word);
    match_valid = match_found && match_status == vwr_pkg::CAP_OK && match_word != 4'h0
      && match_word <= vwr_pkg::MAX_NUMERAL && slot_occupied[match_idx];
  end

  // Edge history of the code, mode and standby levels
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prev_code <= 4'h0;
      train_prev <= 1'b0;
      standby_request_prev <= 1'b0;
    end else if (ce) begin
      prev_code <= code;
      train_prev <= train_sync;
      standby_request_prev <= standby_request_sync;
    end
  end

  // Numeral latch; a later numeral simply replaces an earlier one
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      numeral <= 4'h0;
    end else if (new_code && is_numeral && train_sync && state == vwr_pkg::VWR_READY) begin
      numeral <= code;
    end
  end

  // Active bank; numerals above four wrap modulo four
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bank <= vwr_pkg::BANK_RESET;
      bank_fault <= 1'b0;
    end else if (run && train_sync && !train_prev) begin
      bank <= vwr_pkg::BANK_RESET;
    end else if (cmd_ok && code == vwr_pkg::BANK_SELECT_CMD) begin
      bank <= 2'(numeral - 4'h1);
      bank_fault <= numeral > vwr_pkg::MAX_BANK_NUMERAL;
    end
  end

  // Registration sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= vwr_pkg::VWR_READY;
      slot <= 4'h0;
    end else if (run) begin
      case (state)
        vwr_pkg::VWR_READY: begin
          if (cmd_ok && code == vwr_pkg::STORE_WORD_CMD) begin
            slot <= numeral;
            state <= vwr_pkg::VWR_LISTEN;
          end
        end
        vwr_pkg::VWR_LISTEN: begin
          // The aborting code is swallowed, never decoded
          if (!train_sync || new_code || capture_done) begin
            state <= vwr_pkg::VWR_READY;
          end
        end
        default: state <= vwr_pkg::VWR_READY;
      endcase
    end
  end

  // Slot table, one flag per entry; a store wins over an erase
  generate
    for (genvar i = 0; i < vwr_pkg::SLOT_COUNT; i++) begin : g_slot
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          slot_occupied[i] <= 1'b0;
        end else if (store_hit && store_idx == 6'(i)) begin
          slot_occupied[i] <= 1'b1;
        end else if (erase_all_hit) begin
          slot_occupied[i] <= 1'b0;
        end else if (erase_word_hit && erase_idx == 6'(i)) begin
          slot_occupied[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Result lines; held until a new result, cleared on standby release
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      {result_bank_bit1, result_bank_bit0} <= vwr_pkg::BANK_RESET;
      result_word_lines <= vwr_pkg::WORD_RESET;
    end else if (ce && !standby_request_sync && standby_request_prev) begin
      {result_bank_bit1, result_bank_bit0} <= vwr_pkg::BANK_RESET;
      result_word_lines <= vwr_pkg::WORD_RESET;
    end else if (run && state == vwr_pkg::VWR_LISTEN && capture_done && train_sync) begin
      {result_bank_bit1, result_bank_bit0} <= bank;
      case (capture_status)
        vwr_pkg::CAP_OK: result_word_lines <= slot;
        vwr_pkg::CAP_SHORT: result_word_lines <= vwr_pkg::WORD_TOO_SHORT;
        default: result_word_lines <= vwr_pkg::WORD_TOO_LONG;
      endcase
    end else if (cmd_ok && code == vwr_pkg::BANK_SELECT_CMD) begin
      {result_bank_bit1, result_bank_bit0} <= 2'(numeral - 4'h1);
    end else if (match_hit) begin
      {result_bank_bit1, result_bank_bit0} <= match_bank;
      if (match_status == vwr_pkg::CAP_SHORT) begin
        result_word_lines <= vwr_pkg::WORD_TOO_SHORT;
      end else if (match_status == vwr_pkg::CAP_LONG) begin
        result_word_lines <= vwr_pkg::WORD_TOO_LONG;
      end else if (match_valid) begin
        result_word_lines <= match_word;
      end else begin
        result_word_lines <= vwr_pkg::WORD_NO_MATCH;
      end
    end
  end

  // Done flag drops while speech is taken in
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      result_done_flag <= 1'b0;
    end else if (run) begin
      if ((state == vwr_pkg::VWR_LISTEN && capture_done) || match_hit) begin
        result_done_flag <= 1'b1;
      end else if (listen_enable && speech_active) begin
        result_done_flag <= 1'b0;
      end
    end
  end

  // Hold-off gives the host time to read before new speech lands
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      holdoff <= 17'h0_0000;
    end else if (run) begin
      if (match_hit) begin
        holdoff <= 17'(HOLDOFF_CYCLES);
      end else if (holdoff != 17'h0_0000) begin
        holdoff <= holdoff - 17'h0_0001;
      end
    end
  end

  // Speech gate to the engine and busy indication
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      listen_enable <= 1'b0;
      busy_flag <= 1'b0;
    end else if (ce) begin
      listen_enable <= !standby_request_sync && ctrl[vwr_pkg::CTRL_LISTEN_BIT] && (train_sync
        ? (state == vwr_pkg::VWR_LISTEN && !new_code && !capture_done)
        : (holdoff == 17'h0_0000 && !match_hit));
      busy_flag <= standby_request_sync || (listen_enable && speech_active);
    end
  end

  // APB slave: answers one cycle into the access phase
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl <= vwr_pkg::CTRL_RESET;
    end else if (ce) begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        case (paddr)
          vwr_pkg::CTRL_OFFSET: prdata <= ctrl;
          vwr_pkg::STATUS_OFFSET: prdata <= {19'h0_0000, standby_request_sync, host_sync,
            train_sync, bank_fault, state == vwr_pkg::VWR_LISTEN, busy_flag,
            result_done_flag, result_bank_bit1, result_bank_bit0, result_word_lines};
          vwr_pkg::OCC_LO_OFFSET: prdata <= {12'h000, slot_occupied[19:0]};
          vwr_pkg::OCC_HI_OFFSET: prdata <= {12'h000, slot_occupied[39:20]};
          default: pslverr <= 1'b1;
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == vwr_pkg::CTRL_OFFSET) begin
        ctrl <= {31'h0000_0000, pwdata[0]};
      end
    end
  end

  // Checks on command handling and result timing
  sequence seq_store_cmd;
    cmd_ok && code == vwr_pkg::STORE_WORD_CMD;
  endsequence

  sequence seq_store_ok;
    run && state == vwr_pkg::VWR_LISTEN && capture_done && train_sync
      && capture_status == vwr_pkg::CAP_OK;
  endsequence

  AST_BANK_SELECT: assert property (@(posedge clock) disable iff (!rst_b)
    cmd_ok && code == vwr_pkg::BANK_SELECT_CMD && numeral == 4'h3 |=> bank == 2'h2)
    else $error("bank select did not take numeral");

  AST_TRAIN_ENTRY: assert property (@(posedge clock) disable iff (!rst_b)
    run && train_sync && !train_prev |=> bank == 2'h0)
    else $error("training entry did not select bank one");

  AST_STORE_LISTEN: assert property (@(posedge clock) disable iff (!rst_b)
    seq_store_cmd |=> state == vwr_pkg::VWR_LISTEN && slot == $past(numeral))
    else $error("store command did not wait for speech");

  AST_ABORT: assert property (@(posedge clock) disable iff (!rst_b)
    run && state == vwr_pkg::VWR_LISTEN && new_code
      |=> state == vwr_pkg::VWR_READY && $stable(slot_occupied))
    else $error("code during listen did not abort");

  AST_STORE_RESULT: assert property (@(posedge clock) disable iff (!rst_b)
    seq_store_ok ##1 1'b1 |-> result_word_lines == $past(slot) && result_done_flag
      && {result_bank_bit1, result_bank_bit0} == $past(bank))
    else $error("registration result not presented");

  AST_ERASE_ALL: assert property (@(posedge clock) disable iff (!rst_b)
    erase_all_hit && !store_hit |=> slot_occupied == 40'h00_0000_0000)
    else $error("erase all left entries");

  AST_NO_MATCH: assert property (@(posedge clock) disable iff (!rst_b)
    match_hit && match_status == vwr_pkg::CAP_OK && !match_valid
      |=> result_word_lines == vwr_pkg::WORD_NO_MATCH)
    else $error("no match code missing");

  AST_HOLDOFF: assert property (@(posedge clock) disable iff (!rst_b)
    ce && match_hit |=> !listen_enable [*3])
    else $error("speech accepted during hold-off");

  AST_DONE_LOW: assert property (@(posedge clock) disable iff (!rst_b)
    run && listen_enable && speech_active && !capture_done && !match_hit
      |=> !result_done_flag)
    else $error("done flag high while speech taken in");

endmodule
`default_nettype wire

// ===== test/vwr_host_model.sv
// Host model that drives command codes with idle gaps between them
`timescale 1ns/1ps
`default_nettype none
module vwr_host_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic send,
  input wire logic [3:0] code,
  output logic done,
  output logic [3:0] host_lines
);
  logic [3:0] step;

  // Code stands 4 cycles, then idle 5, so the two-stage sync sees each one
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      step <= 4'h0;
      done <= 1'b0;
      host_lines <= vwr_pkg::IDLE_CODE;
    end else begin
      done <= 1'b0;
      if (step != 4'h0) begin
        step <= (step == 4'h8) ? 4'h0 : step + 4'h1;
        if (step == 4'h4) host_lines <= vwr_pkg::IDLE_CODE;
        if (step == 4'h8) done <= 1'b1;
      end else if (send && !done) begin
        step <= 4'h1;
        // Forbidden code never reaches the lines
        host_lines <= (code == vwr_pkg::FORBIDDEN_CODE) ? vwr_pkg::IDLE_CODE : code;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_vwr_command_core.sv
// Testbench for the word registration command block
`timescale 1ns/1ps
`default_nettype none
module tb_vwr_command_core;
  localparam int HOLD = 20;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic train_mode_select = 1'b1;
  logic host_control_select = 1'b1;
  logic standby_request = 1'b0;
  logic speech_active = 1'b0;
  logic capture_done = 1'b0;
  logic [1:0] capture_status = 2'h0;
  logic match_done = 1'b0;
  logic match_found = 1'b0;
  logic [1:0] match_status = 2'h0;
  logic [1:0] match_bank = 2'h0;
  logic [3:0] match_word = 4'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic send = 1'b0;
  logic [3:0] code = 4'h0;
  logic done, pready, pslverr, err, result_bank_bit0, result_bank_bit1;
  logic result_done_flag, busy_flag, listen_enable;
  logic [3:0] host_lines, result_word_lines;
  logic [31:0] prdata, q;
  logic [39:0] slot_occupied;
  logic [1:0] bank;
  int n_fail = 0;
  int n_tests = 0;

  assign bank = {result_bank_bit1, result_bank_bit0};

  // 100 ns period
  always #50 clock = ~clock;

  vwr_command_core #(.HOLDOFF_CYCLES(HOLD)) i_vwr_command_core (
    .clock(clock), .rst_b(rst_b), .ce(ce),
    .command_nibble_lines(host_control_select ? host_lines : 4'h0),
    .keypad_code(host_control_select ? 4'h0 : host_lines),
    .train_mode_select(train_mode_select), .host_control_select(host_control_select),
    .standby_request(standby_request), .speech_active(speech_active),
    .capture_done(capture_done), .capture_status(capture_status),
    .match_done(match_done), .match_found(match_found), .match_status(match_status),
    .match_bank(match_bank), .match_word(match_word), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .result_bank_bit0(result_bank_bit0),
    .result_bank_bit1(result_bank_bit1), .result_word_lines(result_word_lines),
    .result_done_flag(result_done_flag), .busy_flag(busy_flag),
    .listen_enable(listen_enable), .slot_occupied(slot_occupied)
  );

  vwr_host_model i_vwr_host_model (
    .clock(clock), .rst_b(rst_b), .send(send), .code(code), .done(done),
    .host_lines(host_lines)
  );

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask

  // Hand one code to the host model and wait until it has gone idle again
  task automatic put(input logic [3:0] c);
    int n;
    n = 0;
    @(posedge clock);
    send <= 1'b1;
    code <= c;
    @(posedge clock);
    while (done !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    send <= 1'b0;
    check(done, 1'b1);
  endtask

  task automatic await(input logic v);
    int n;
    n = 0;
    while (listen_enable !== v && n < 200) begin
      @(posedge clock);
      n++;
    end
    check(listen_enable, v);
  endtask

  // APB transfer held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    q = prdata;
    err = pslverr;
    check(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Numeral, store command, speech, then capture outcome
  task automatic store(input logic [3:0] w, input logic [1:0] st);
    put(w);
    put(vwr_pkg::STORE_WORD_CMD);
    await(1'b1);
    @(posedge clock);
    speech_active <= 1'b1;
    ticks(3);
    check({result_done_flag, busy_flag}, 2'b01);
    speech_active <= 1'b0;
    capture_done <= 1'b1;
    capture_status <= st;
    @(posedge clock);
    capture_done <= 1'b0;
    @(negedge clock);
  endtask

  task automatic recog(input logic f, input logic [1:0] st, input logic [1:0] b,
                       input logic [3:0] w);
    await(1'b1);
    @(posedge clock);
    match_done <= 1'b1;
    match_found <= f;
    match_status <= st;
    match_bank <= b;
    match_word <= w;
    @(posedge clock);
    match_done <= 1'b0;
    @(negedge clock);
  endtask

  initial begin
    ticks(5);
    rst_b <= 1'b1;
    @(negedge clock);
    check({bank, result_word_lines, result_done_flag}, 7'h00);
    ticks(3);
    store(4'h3, vwr_pkg::CAP_OK);
    check({bank, result_word_lines, result_done_flag}, {2'h0, 4'h3, 1'b1});
    apb(1'b0, vwr_pkg::STATUS_OFFSET, 32'h0000_0000);
    check({err, q[12:0]}, 14'h0C43);
    fin("register");
    // Numeral above four wraps; the latest numeral wins
    put(4'h6);
    put(vwr_pkg::BANK_SELECT_CMD);
    check(bank, 2'h1);
    apb(1'b0, vwr_pkg::STATUS_OFFSET, 32'h0000_0000);
    check({err, q[9]}, 2'b01);
    put(4'h4);
    put(4'h3);
    put(vwr_pkg::BANK_SELECT_CMD);
    check(bank, 2'h2);
    store(4'hA, vwr_pkg::CAP_OK);
    check({bank, result_word_lines}, {2'h2, 4'hA});
    apb(1'b0, vwr_pkg::OCC_HI_OFFSET, 32'h0000_0000);
    check({err, q}, 33'h0_0000_0200);
    standby_request <= 1'b1;
    ticks(5);
    check({busy_flag, slot_occupied}, {1'b1, 40'h00_2000_0004});
    standby_request <= 1'b0;
    ticks(5);
    fin("bank");
    // Too short and too long captures leave the slot empty
    for (int i = 1; i < 3; i++) begin
      store(4'h5, i[1:0]);
      check({result_word_lines, slot_occupied[24]}, {4'hD + i[3:0], 1'b0});
    end
    // Any code while awaiting speech aborts and is discarded
    put(4'h7);
    put(vwr_pkg::STORE_WORD_CMD);
    await(1'b1);
    put(4'h1);
    check({listen_enable, slot_occupied[26], bank}, 4'h2);
    put(4'hA);
    put(vwr_pkg::ERASE_WORD_CMD);
    ticks(2);
    check(slot_occupied, 40'h00_0000_0004);
    // Keypad path selected by the host-control input
    host_control_select <= 1'b0;
    ticks(5);
    put(4'h1);
    put(vwr_pkg::BANK_SELECT_CMD);
    check(bank, 2'h0);
    host_control_select <= 1'b1;
    ticks(5);
    // Clock enable low freezes decode, so this bank select is lost
    ce <= 1'b0;
    put(4'h2);
    put(vwr_pkg::BANK_SELECT_CMD);
    ce <= 1'b1;
    ticks(5);
    check(bank, 2'h0);
    fin("errors");
    train_mode_select <= 1'b0;
    recog(1'b1, vwr_pkg::CAP_OK, 2'h0, 4'h3);
    check({bank, result_word_lines, result_done_flag, listen_enable}, 8'h0E);
    ticks(HOLD - 5);
    check(listen_enable, 1'b0);
    recog(1'b1, vwr_pkg::CAP_OK, 2'h3, 4'h9);
    check(result_word_lines, vwr_pkg::WORD_NO_MATCH);
    recog(1'b0, vwr_pkg::CAP_OK, 2'h0, 4'h3);
    check(result_word_lines, vwr_pkg::WORD_NO_MATCH);
    recog(1'b1, vwr_pkg::CAP_LONG, 2'h0, 4'h3);
    check({result_word_lines, result_done_flag}, {vwr_pkg::WORD_TOO_LONG, 1'b1});
    // Control register, unmapped place, listen gate
    apb(1'b0, vwr_pkg::CTRL_OFFSET, 32'h0000_0000);
    check({err, q}, {1'b0, vwr_pkg::CTRL_RESET});
    apb(1'b0, 12'h010, 32'h0000_0000);
    check({err, q}, {1'b1, 32'h0000_0000});
    apb(1'b1, vwr_pkg::CTRL_OFFSET, 32'h0000_0000);
    ticks(HOLD + 5);
    check(listen_enable, 1'b0);
    apb(1'b1, vwr_pkg::CTRL_OFFSET, 32'h0000_0001);
    train_mode_select <= 1'b1;
    ticks(5);
    put(vwr_pkg::ERASE_ALL_CMD);
    ticks(2);
    check(slot_occupied, 40'h00_0000_0000);
    fin("recognition");
    conclude();
  end

  // Tests take several hundred cycles; this limit is far beyond that
  initial begin
    ticks(20000);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
